// ===== design/dlrtc_regs.vh
`ifndef DLRTC_REGS_VH
`define DLRTC_REGS_VH
// ************************************************************
// register word offsets
// ************************************************************
`define DLRTC_OFS_MODEL_ID       16'hA233
`define DLRTC_OFS_MODEL_LEN      16'hA234
`define DLRTC_OFS_SET_DATE_LO    16'hA235
`define DLRTC_OFS_SET_DATE_HI    16'hA236
`define DLRTC_OFS_SET_TIME_LO    16'hA237
`define DLRTC_OFS_SET_TIME_HI    16'hA238
`define DLRTC_OFS_GET_DATE_LO    16'hA239
`define DLRTC_OFS_GET_DATE_HI    16'hA23A
`define DLRTC_OFS_GET_TIME_LO    16'hA23B
`define DLRTC_OFS_GET_TIME_HI    16'hA23C
`define DLRTC_OFS_SAMPLE_PERIOD  16'hA23D
`define DLRTC_OFS_VALID_COUNT    16'hA23E
`define DLRTC_OFS_FACTORY_CMD_A  16'hA23F
`define DLRTC_OFS_FACTORY_STAT   16'hA240
`define DLRTC_OFS_LOG_SELECT     16'hA241
`define DLRTC_OFS_FETCH_HEADER   16'hA242
`define DLRTC_OFS_FETCH_RECORD   16'hA243
`define DLRTC_OFS_FACTORY_CMD_B  16'hA244
// ************************************************************
// field positions
// ************************************************************
`define DLRTC_YEAR_MSB       13
`define DLRTC_YEAR_LSB       0
`define DLRTC_DATE_SET_BIT   14
`define DLRTC_MONTH_MSB      23
`define DLRTC_MONTH_LSB      16
`define DLRTC_DAY_MSB        31
`define DLRTC_DAY_LSB        24
`define DLRTC_HOUR_MSB       7
`define DLRTC_HOUR_LSB       0
`define DLRTC_MIN_MSB        15
`define DLRTC_MIN_LSB        8
`define DLRTC_SEC_MSB        23
`define DLRTC_SEC_LSB        16
`define DLRTC_TIME_SET_BIT   31
// ************************************************************
// values
// ************************************************************
`define DLRTC_MODEL_LEN      16'h007E
`define DLRTC_SAMPLE_MS      16'h0001
`define DLRTC_MAX_LOGS       16'h000C
`define DLRTC_LAST_LOG       16'h000B
`define DLRTC_HDR_FETCH      16'h0001
`define DLRTC_RST_WORD       16'h0000
// ************************************************************
// timing
// ************************************************************
`define DLRTC_SECOND_NS      32'h3B9ACA00
`define DLRTC_CLK_PERIOD_NS  32'h00000005
`endif

// ===== design/dlrtc_register_model.v
// Operation
// RQ1 - the set-date word holds year in the low bits, month in bits 23 to 16 and day in the top bits.
// RQ2 - a written date is only held, and the clock date stays unchanged until the set-time word is written.
// RQ3 - writing the set-time word loads the time and commits the held date in the same cycle.
// RQ4 - the host writes the set-date word before the set-time word.
// RQ5 - the set-time word holds hours in bits 7 to 0, minutes in 15 to 8 and seconds in 23 to 16.
// RQ6 - bits 15 to 14 of the set-date word and 31 to 24 of the set-time word are ignored.
// RQ7 - the get-date word returns the date fields with bit 14 set once the date was set since reset.
// RQ8 - the get-time word returns the time fields with bit 31 set once the time was set since reset.
// RQ9 - reading the get-date word snapshots the time, and get-time reads return that snapshot.
// RQ10 - the host reads the get-date word before the get-time word.
// RQ11 - the sample-period word is read-only and reads one millisecond.
// RQ12 - the valid-log count is read-only and reads from zero to twelve.
// RQ13 - the host selects a log from 0 to 11 and later fetches act on that log.
// RQ14 - writing one to the fetch-header word fetches the selected header, writing zero does nothing.
// RQ15 - writing a record number to the record-fetch word fetches that record of the selected log.
// RQ16 - the model header holds a read-only identifier and a length word of 126.
// RQ17 - once set, the clock advances one second per second with full calendar rollover.
//
// Decided for this implementation: the plain strobed port.
`include "dlrtc_regs.vh"
module dlrtc_register_model #(
    parameter [15:0] MODEL_ID        = 16'hD10C, // arbitrary value
    parameter [31:0] TICKS_PER_SEC   = `DLRTC_SECOND_NS / `DLRTC_CLK_PERIOD_NS
) (
    input  wire        clock_i,
    input  wire        srst_i,
    input  wire [15:0] addr_i,
    input  wire [15:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [15:0] rdata_o,
    input  wire [15:0] log_count_i,
    output reg  [3:0]  log_select_o,
    output reg         fetch_header_o,
    output reg         fetch_record_o,
    output reg  [15:0] record_num_o
);
    // ************************************************************
    // state
    // ************************************************************
    reg [31:0] held_date;
    reg [15:0] held_time_lo;
    reg [15:0] held_time_hi;
    reg [13:0] year;
    reg [7:0]  month;
    reg [7:0]  day;
    reg [7:0]  hour;
    reg [7:0]  minute;
    reg [7:0]  second;
    reg        date_set;
    reg        time_set;
    reg [31:0] snap_date;
    reg [31:0] snap_time;
    reg [31:0] tick_cnt;
    reg [15:0] header_word;

    reg [13:0] next_year;
    reg [7:0]  next_month;
    reg [7:0]  next_day;
    reg [7:0]  next_hour;
    reg [7:0]  next_minute;
    reg [7:0]  next_second;
    reg [7:0]  days_in_month;
    reg        leap;
    reg [15:0] next_rdata;
    reg [15:0] count_clamped;

    wire        tick = time_set && (tick_cnt == TICKS_PER_SEC - 32'h00000001);
    wire        commit = wr_i && (addr_i == `DLRTC_OFS_SET_TIME_HI);
    wire [31:0] live_date;
    wire [31:0] live_time;

    assign live_date = {day, month, 1'b0, date_set, year}; // RQ7
    assign live_time = {time_set, 7'h00, second, minute, hour}; // RQ8

    // ************************************************************
    // calendar rollover
    // ************************************************************
    wire        sec_wrap   = tick && (second >= 8'h3B);
    wire        min_wrap   = sec_wrap && (minute >= 8'h3B);
    wire        hour_wrap  = min_wrap && (hour >= 8'h17);
    wire        day_wrap   = hour_wrap && (day >= days_in_month);
    wire        month_wrap = day_wrap && (month >= 8'h0C);

    // month length with gregorian leap years
    always @* begin
        leap = (year[1:0] == 2'h0) && (((year % 14'h0064) != 14'h0000) || ((year % 14'h0190) == 14'h0000));
        case (month)
            8'h02: days_in_month = leap ? 8'h1D : 8'h1C;
            8'h04, 8'h06, 8'h09, 8'h0B: days_in_month = 8'h1E;
            default: days_in_month = 8'h1F;
        endcase
    end

    always @* begin
        next_second = second;
        if (sec_wrap) begin // RQ17
            next_second = 8'h00;
        end else if (tick) begin
            next_second = second + 8'h01;
        end
    end

    always @* begin
        next_minute = minute;
        if (min_wrap) begin // RQ17
            next_minute = 8'h00;
        end else if (sec_wrap) begin
            next_minute = minute + 8'h01;
        end
    end

    always @* begin
        next_hour = hour;
        if (hour_wrap) begin // RQ17
            next_hour = 8'h00;
        end else if (min_wrap) begin
            next_hour = hour + 8'h01;
        end
    end

    // out of range set values only roll at the next carry
    always @* begin
        next_day = day;
        if (day_wrap) begin // RQ17
            next_day = 8'h01;
        end else if (hour_wrap) begin
            next_day = day + 8'h01;
        end
    end

    always @* begin
        next_month = month;
        if (month_wrap) begin // RQ17
            next_month = 8'h01;
        end else if (day_wrap) begin
            next_month = month + 8'h01;
        end
    end

    always @* begin
        next_year = year;
        if (month_wrap) begin // RQ17
            next_year = year + 14'h0001;
        end
    end

    // ************************************************************
    // held set words
    // ************************************************************
    always @(posedge clock_i) begin
        if (srst_i) begin
            held_date    <= 32'h00000000;
            held_time_lo <= `DLRTC_RST_WORD;
            held_time_hi <= `DLRTC_RST_WORD;
        end else begin
            if (wr_i && addr_i == `DLRTC_OFS_SET_DATE_LO) begin
                held_date[15:0] <= wdata_i; // RQ2
            end
            if (wr_i && addr_i == `DLRTC_OFS_SET_DATE_HI) begin
                held_date[31:16] <= wdata_i; // RQ2
            end
            if (wr_i && addr_i == `DLRTC_OFS_SET_TIME_LO) begin
                held_time_lo <= wdata_i;
            end
            if (commit) begin // RQ3
                held_time_hi <= wdata_i;
            end
        end
    end

    // ************************************************************
    // time of day
    // ************************************************************
    always @(posedge clock_i) begin
        if (srst_i) begin
            hour <= 8'h00;
        end else if (commit) begin
            hour <= held_time_lo[`DLRTC_HOUR_MSB:`DLRTC_HOUR_LSB]; // RQ5
        end else begin
            hour <= next_hour;
        end
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            minute <= 8'h00;
        end else if (commit) begin
            minute <= held_time_lo[`DLRTC_MIN_MSB:`DLRTC_MIN_LSB]; // RQ5
        end else begin
            minute <= next_minute;
        end
    end

    // seconds sit in the low byte of the upper half word
    always @(posedge clock_i) begin
        if (srst_i) begin
            second <= 8'h00;
        end else if (commit) begin
            second <= wdata_i[7:0]; // RQ5 RQ6
        end else begin
            second <= next_second;
        end
    end

    // ************************************************************
    // calendar date
    // ************************************************************
    always @(posedge clock_i) begin
        if (srst_i) begin
            year <= 14'h0000;
        end else if (commit) begin
            year <= held_date[`DLRTC_YEAR_MSB:`DLRTC_YEAR_LSB]; // RQ1 RQ3 RQ6
        end else begin
            year <= next_year;
        end
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            month <= 8'h00;
        end else if (commit) begin
            month <= held_date[`DLRTC_MONTH_MSB:`DLRTC_MONTH_LSB]; // RQ1
        end else begin
            month <= next_month;
        end
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            day <= 8'h00;
        end else if (commit) begin
            day <= held_date[`DLRTC_DAY_MSB:`DLRTC_DAY_LSB]; // RQ1
        end else begin
            day <= next_day;
        end
    end

    // ************************************************************
    // set status flags
    // ************************************************************
    always @(posedge clock_i) begin
        if (srst_i) begin
            date_set <= 1'b0;
            time_set <= 1'b0;
        end else if (commit) begin
            date_set <= 1'b1; // RQ7
            time_set <= 1'b1; // RQ8
        end
    end

    // ************************************************************
    // second divider
    // ************************************************************
    always @(posedge clock_i) begin
        if (srst_i) begin
            tick_cnt <= 32'h00000000;
        end else if (commit || tick || !time_set) begin
            // restart the second so the new time holds a full second
            tick_cnt <= 32'h00000000;
        end else begin
            tick_cnt <= tick_cnt + 32'h00000001; // RQ17
        end
    end

    // ************************************************************
    // snapshot on get-date read
    // ************************************************************
    always @(posedge clock_i) begin
        if (srst_i) begin
            snap_date <= 32'h00000000;
            snap_time <= 32'h00000000;
        end else if (rd_i && addr_i == `DLRTC_OFS_GET_DATE_LO) begin
            // one capture keeps date and time coherent across a midnight roll
            snap_date <= live_date; // RQ9
            snap_time <= live_time; // RQ9 RQ10
        end
    end

    // ************************************************************
    // fault log select
    // ************************************************************
    always @(posedge clock_i) begin
        if (srst_i) begin
            log_select_o <= 4'h0;
        end else if (wr_i && addr_i == `DLRTC_OFS_LOG_SELECT && wdata_i <= `DLRTC_LAST_LOG) begin
            // out of range index keeps the old selection
            log_select_o <= wdata_i[3:0]; // RQ13
        end
    end

    // ************************************************************
    // header fetch
    // ************************************************************
    always @(posedge clock_i) begin
        if (srst_i) begin
            header_word    <= `DLRTC_RST_WORD;
            fetch_header_o <= 1'b0;
        end else if (wr_i && addr_i == `DLRTC_OFS_FETCH_HEADER) begin
            header_word    <= wdata_i;
            fetch_header_o <= (wdata_i == `DLRTC_HDR_FETCH); // RQ14
        end else begin
            fetch_header_o <= 1'b0;
        end
    end

    // ************************************************************
    // record fetch
    // ************************************************************
    always @(posedge clock_i) begin
        if (srst_i) begin
            record_num_o   <= `DLRTC_RST_WORD;
            fetch_record_o <= 1'b0;
        end else if (wr_i && addr_i == `DLRTC_OFS_FETCH_RECORD) begin
            record_num_o   <= wdata_i; // RQ15
            fetch_record_o <= 1'b1; // RQ15
        end else begin
            fetch_record_o <= 1'b0;
        end
    end

    // ************************************************************
    // read mux
    // ************************************************************
    always @* begin
        count_clamped = (log_count_i > `DLRTC_MAX_LOGS) ? `DLRTC_MAX_LOGS : log_count_i;
        case (addr_i)
            `DLRTC_OFS_MODEL_ID:      next_rdata = MODEL_ID; // RQ16
            `DLRTC_OFS_MODEL_LEN:     next_rdata = `DLRTC_MODEL_LEN; // RQ16
            `DLRTC_OFS_SET_DATE_LO:   next_rdata = held_date[15:0];
            `DLRTC_OFS_SET_DATE_HI:   next_rdata = held_date[31:16];
            `DLRTC_OFS_SET_TIME_LO:   next_rdata = held_time_lo;
            `DLRTC_OFS_SET_TIME_HI:   next_rdata = held_time_hi;
            `DLRTC_OFS_GET_DATE_LO:   next_rdata = live_date[15:0]; // RQ7
            `DLRTC_OFS_GET_DATE_HI:   next_rdata = snap_date[31:16]; // RQ7
            `DLRTC_OFS_GET_TIME_LO:   next_rdata = snap_time[15:0]; // RQ9
            `DLRTC_OFS_GET_TIME_HI:   next_rdata = snap_time[31:16]; // RQ9
            `DLRTC_OFS_SAMPLE_PERIOD: next_rdata = `DLRTC_SAMPLE_MS; // RQ11
            `DLRTC_OFS_VALID_COUNT:   next_rdata = count_clamped; // RQ12
            `DLRTC_OFS_LOG_SELECT:    next_rdata = {12'h000, log_select_o};
            `DLRTC_OFS_FETCH_HEADER:  next_rdata = header_word;
            `DLRTC_OFS_FETCH_RECORD:  next_rdata = record_num_o;
            default:                  next_rdata = 16'h0000;
        endcase
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= 16'h0000;
        end
    end
endmodule // dlrtc_register_model

// ===== dv/dlrtc_register_model_checker.sv
`include "dlrtc_regs.vh"
module dlrtc_register_model_checker (
    input wire logic        clock_i,
    input wire logic        srst_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic [15:0] log_count_i,
    input wire logic [3:0]  log_select_o,
    input wire logic        fetch_header_o,
    input wire logic        fetch_record_o,
    input wire logic [15:0] record_num_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ************************************************************
    // port relations
    // ************************************************************
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    property p_len; rd_i && addr_i == `DLRTC_OFS_MODEL_LEN |=> rdata_o == `DLRTC_MODEL_LEN; endproperty
    a_len: assert property (p_len) else $error("length word wrong");
    property p_period; rd_i && addr_i == `DLRTC_OFS_SAMPLE_PERIOD |=> rdata_o == `DLRTC_SAMPLE_MS; endproperty
    a_period: assert property (p_period) else $error("sample period wrong");
    property p_count; rd_i && addr_i == `DLRTC_OFS_VALID_COUNT |=>
        rdata_o == ($past(log_count_i) > `DLRTC_MAX_LOGS ? `DLRTC_MAX_LOGS : $past(log_count_i)); endproperty
    a_count: assert property (p_count) else $error("log count wrong");
    property p_hdr; 1 |=> fetch_header_o == $past(wr_i && addr_i == `DLRTC_OFS_FETCH_HEADER && wdata_i == 16'h0001); endproperty
    a_hdr: assert property (p_hdr) else $error("header fetch pulse wrong");
    property p_rec; wr_i && addr_i == `DLRTC_OFS_FETCH_RECORD |=> fetch_record_o && record_num_o == $past(wdata_i); endproperty
    a_rec: assert property (p_rec) else $error("record fetch missing");
    property p_rec_cause; fetch_record_o |-> $past(wr_i && addr_i == `DLRTC_OFS_FETCH_RECORD); endproperty
    a_rec_cause: assert property (p_rec_cause) else $error("record fetch without write");
    property p_sel; wr_i && addr_i == `DLRTC_OFS_LOG_SELECT && wdata_i <= `DLRTC_LAST_LOG |=> log_select_o == $past(wdata_i[3:0]); endproperty
    a_sel: assert property (p_sel) else $error("log select not taken");
    property p_sel_keep; wr_i && addr_i == `DLRTC_OFS_LOG_SELECT && wdata_i > `DLRTC_LAST_LOG |=> $stable(log_select_o); endproperty
    a_sel_keep: assert property (p_sel_keep) else $error("bad log select taken");
    property p_rsvd; rd_i && addr_i == `DLRTC_OFS_FACTORY_STAT |=> rdata_o == 16'h0000; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved word not zero");
    c_hdr: cover property (fetch_header_o);
    c_rec: cover property (fetch_record_o);
    c_sel_refused: cover property (wr_i && addr_i == `DLRTC_OFS_LOG_SELECT && wdata_i > `DLRTC_LAST_LOG);
endmodule // dlrtc_register_model_checker
bind dlrtc_register_model dlrtc_register_model_checker dlrtc_register_model_checker_i (
    .clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .log_count_i(log_count_i), .log_select_o(log_select_o), .fetch_header_o(fetch_header_o),
    .fetch_record_o(fetch_record_o), .record_num_o(record_num_o));

// ===== dv/dlrtc_log_store.sv
module dlrtc_log_store (
    input  wire logic        clock_i,
    input  wire logic [15:0] n_logs_i,
    input  wire logic [3:0]  log_select_i,
    input  wire logic        fetch_header_i,
    input  wire logic        fetch_record_i,
    input  wire logic [15:0] record_num_i,
    output logic      [15:0] log_count_o,
    output logic      [7:0]  n_hdr_o = 8'h00,
    output logic      [7:0]  n_rec_o = 8'h00,
    output logic      [3:0]  last_log_o = 4'h0,
    output logic      [15:0] last_rec_o = 16'h0000
);
    timeunit 1ns;
    timeprecision 100ps;
    // ************************************************************
    // log store seen by the fetch pulses
    // ************************************************************
    assign log_count_o = n_logs_i;
    // header fetches record the log selected at pulse time
    always @(posedge clock_i) begin
        if (fetch_header_i) begin
            n_hdr_o <= n_hdr_o + 8'h01;
            last_log_o <= log_select_i;
        end
        if (fetch_record_i) begin
            n_rec_o <= n_rec_o + 8'h01;
            last_rec_o <= record_num_i;
        end
    end
endmodule // dlrtc_log_store

// ===== dv/tb_dlrtc_register_model.sv
`include "dlrtc_regs.vh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin n_fail++; $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module tb_dlrtc_register_model;
    timeunit 1ns;
    timeprecision 100ps;
    localparam [15:0] ID = 16'h5A5A; // arbitrary value
    logic        clock_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [15:0] wdata_i = 16'h0000;
    logic [15:0] n_logs = 16'h0000;
    logic [15:0] rdata_o, log_count_i, record_num_o, last_rec;
    logic        fetch_header_o, fetch_record_o;
    logic [3:0]  log_select_o, last_log;
    logic [7:0]  n_hdr, n_rec;
    logic [15:0] cnts [3] = '{16'h0000, 16'h0005, 16'h000C};
    int          n_fail = 0;
    int          check_count = 0;
    int          cycles = 0;
    always #2.5 clock_i = ~clock_i;
    dlrtc_register_model #(.MODEL_ID(ID), .TICKS_PER_SEC(32'h0000000A)) dlrtc_register_model_i (
        .clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .log_count_i(log_count_i), .log_select_o(log_select_o),
        .fetch_header_o(fetch_header_o), .fetch_record_o(fetch_record_o), .record_num_o(record_num_o));
    dlrtc_log_store dlrtc_log_store_i (.clock_i(clock_i), .n_logs_i(n_logs), .log_select_i(log_select_o),
        .fetch_header_i(fetch_header_o), .fetch_record_i(fetch_record_o), .record_num_i(record_num_o),
        .log_count_o(log_count_i), .n_hdr_o(n_hdr), .n_rec_o(n_rec), .last_log_o(last_log), .last_rec_o(last_rec));
    // ************************************************************
    // bus tasks and verdict
    // ************************************************************
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string nm);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(posedge clock_i);
        `CHK(nm, exp, rdata_o)
    endtask
    task automatic give_verdict;
        $display("mismatches %0d comparisons %0d", n_fail, check_count);
        if (n_fail == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge clock_i);
        srst_i <= 1'b0;
        @(posedge clock_i);
        rd(`DLRTC_OFS_MODEL_ID, ID, "id");
        wr(`DLRTC_OFS_MODEL_LEN, 16'hFFFF);
        rd(`DLRTC_OFS_MODEL_LEN, `DLRTC_MODEL_LEN, "len");
        rd(`DLRTC_OFS_SAMPLE_PERIOD, `DLRTC_SAMPLE_MS, "period");
        rd(`DLRTC_OFS_FACTORY_STAT, 16'h0000, "reserved");
        foreach (cnts[i]) begin
            n_logs <= cnts[i];
            rd(`DLRTC_OFS_VALID_COUNT, cnts[i], "count");
        end
        rd(`DLRTC_OFS_GET_DATE_LO, 16'h0000, "date unset");
        rd(`DLRTC_OFS_GET_TIME_HI, 16'h0000, "time unset");
        wr(`DLRTC_OFS_SET_DATE_LO, 16'hC7E1);
        wr(`DLRTC_OFS_SET_DATE_HI, 16'h1503);
        rd(`DLRTC_OFS_GET_DATE_LO, 16'h0000, "date held");
        rd(`DLRTC_OFS_GET_DATE_HI, 16'h0000, "date held hi");
        wr(`DLRTC_OFS_SET_TIME_LO, 16'h300D);
        wr(`DLRTC_OFS_SET_TIME_HI, 16'hFF05);
        rd(`DLRTC_OFS_GET_DATE_LO, 16'h47E1, "year");
        rd(`DLRTC_OFS_GET_DATE_HI, 16'h1503, "month day");
        rd(`DLRTC_OFS_GET_TIME_LO, 16'h300D, "hour min");
        rd(`DLRTC_OFS_GET_TIME_HI, 16'h8005, "sec");
        // reads land mid-second so a one-cycle tick offset cannot matter
        repeat (24) @(posedge clock_i);
        rd(`DLRTC_OFS_GET_TIME_HI, 16'h8005, "snapshot");
        rd(`DLRTC_OFS_GET_DATE_LO, 16'h47E1, "date again");
        rd(`DLRTC_OFS_GET_TIME_HI, 16'h8008, "sec live");
        wr(`DLRTC_OFS_SET_DATE_LO, 16'h07E7);
        wr(`DLRTC_OFS_SET_DATE_HI, 16'h1F0C);
        wr(`DLRTC_OFS_SET_TIME_LO, 16'h3B17);
        wr(`DLRTC_OFS_SET_TIME_HI, 16'h003B);
        repeat (14) @(posedge clock_i);
        rd(`DLRTC_OFS_GET_DATE_LO, 16'h47E8, "year roll");
        rd(`DLRTC_OFS_GET_DATE_HI, 16'h0101, "month roll");
        rd(`DLRTC_OFS_GET_TIME_LO, 16'h0000, "hour roll");
        rd(`DLRTC_OFS_GET_TIME_HI, 16'h8000, "sec roll");
        wr(`DLRTC_OFS_LOG_SELECT, 16'h000B);
        wr(`DLRTC_OFS_LOG_SELECT, 16'h000C);
        `CHK("select", 4'hB, log_select_o)
        wr(`DLRTC_OFS_FETCH_HEADER, 16'h0000);
        wr(`DLRTC_OFS_FETCH_HEADER, `DLRTC_HDR_FETCH);
        wr(`DLRTC_OFS_FETCH_RECORD, 16'hFFFF);
        @(posedge clock_i);
        #1;
        `CHK("header fetches", 8'h01, n_hdr)
        `CHK("header log", 4'hB, last_log)
        `CHK("record fetches", 8'h01, n_rec)
        `CHK("record number", 16'hFFFF, last_rec)
        give_verdict();
    end
endmodule // tb_dlrtc_register_model
